/* hw/pll_feedback_divider_powerdown.sv */
/*
 * Dual-loop feedback divider with per-loop sleep control, programmed by a
 * three-wire serial port (data, clock, latch strobe).
 * Assumes serial pins and rf/osc tick pulses are synchronous to ref_clk.
 * Loop 0 is the main (high band) loop, loop 1 the second (low band) loop.
 */
`include "pll_fb_consts.svh"

// Behaviour
// - Coarse count is word bits 17..5, legal 3 to 8191.
// - Swallow count is word bits 4..0, range 0 to 31.
// - Bit 18 picks modulus pair: high band 16/17 or 32/33, low 8/9 or 16/17.
// - Feedback ratio is P times coarse plus swallow.
// - Reference divider is 15 bits, ratio 3 to 32767.
// - Bit 19 sleeps the whole loop; pump float bit picks immediate or pump-synced sleep.
// - Sleeping loop holds reference and feedback counters in reset.
// - Leaving sleep, both counters start from zero.
// - Pump float clear: sleep waits until the pump pulse finishes.
// - Pump float set: sleep takes effect at once.
// - Reference input buffer off only when both loops sleep.
// - Address 11 loads main feedback word, 01 the second loop's.
// - Serial data MSB first, sampled on serial clock rising edge.
module pll_feedback_divider_powerdown
    import pll_fb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_latch_strobe,
    input wire logic osc_tick,
    input wire logic main_rf_tick,
    input wire logic second_rf_tick,
    output logic main_ref_pulse,
    output logic main_fb_pulse,
    output logic main_pump_up,
    output logic main_pump_down,
    output logic main_pump_high_impedance,
    output logic main_loop_sleep,
    output logic second_ref_pulse,
    output logic second_fb_pulse,
    output logic second_pump_up,
    output logic second_pump_down,
    output logic second_pump_high_impedance,
    output logic second_loop_sleep,
    output logic reference_input_buffer
);
    logic [`SHIFT_WIDTH-1:0] shift_reg;
    logic serial_clock_reg, latch_strobe_reg;
    logic [`FB_WORD_WIDTH-1:0] main_loop_feedback_word, aux_loop_feedback_word;
    logic [`FB_WORD_WIDTH-1:0] main_ref_word_reg, second_ref_word_reg;
    logic buffer_on_reg;

    // Edge detection on the serial pins; pins are already in this domain
    wire sclk_rise = serial_clock && !serial_clock_reg;
    wire latch_rise = serial_latch_strobe && !latch_strobe_reg;
    wire [1:0] addr = shift_reg[`ADDR_MSB:0];
    wire [`FB_WORD_WIDTH-1:0] data_field = shift_reg[`DATA_MSB:`DATA_LSB];
    wire load_main_fb = latch_rise && (addr == `ADDR_MAIN_FB);
    wire load_second_fb = latch_rise && (addr == `ADDR_SECOND_FB);
    wire load_main_ref = latch_rise && (addr == `ADDR_MAIN_REF);
    wire load_second_ref = latch_rise && (addr == `ADDR_SECOND_REF);

    // Shift register, MSB first; keeps loading in every sleep mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            serial_clock_reg <= 1'b0;
            latch_strobe_reg <= 1'b0;
            shift_reg <= 22'h000000;
        end else begin
            serial_clock_reg <= serial_clock;
            latch_strobe_reg <= serial_latch_strobe;
            if (sclk_rise) begin
                shift_reg <= {shift_reg[`SHIFT_WIDTH-2:0], serial_data};
            end
        end
    end

    // Write-only control words, latched on the strobe's rising edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            main_loop_feedback_word <= `FB_WORD_RESET;
            aux_loop_feedback_word <= `FB_WORD_RESET;
            main_ref_word_reg <= `REF_WORD_RESET;
            second_ref_word_reg <= `REF_WORD_RESET;
        end else begin
            if (load_main_fb) begin
                main_loop_feedback_word <= data_field;
            end
            if (load_second_fb) begin
                aux_loop_feedback_word <= data_field;
            end
            if (load_main_ref) begin
                main_ref_word_reg <= data_field;
            end
            if (load_second_ref) begin
                second_ref_word_reg <= data_field;
            end
        end
    end

    // Per-loop views gathered into arrays for the generate loop
    wire [`FB_WORD_WIDTH-1:0] fb_word [2];
    wire [`FB_WORD_WIDTH-1:0] ref_word [2];
    wire [1:0] rf_tick = {second_rf_tick, main_rf_tick};
    wire [1:0] ref_pulse, fb_pulse, pump_up, pump_down, pump_busy, asleep, pump_float;
    assign fb_word[0] = main_loop_feedback_word;
    assign fb_word[1] = aux_loop_feedback_word;
    assign ref_word[0] = main_ref_word_reg;
    assign ref_word[1] = second_ref_word_reg;

    for (genvar i = 0; i < 2; i++) begin : g_loop
        sleep_state_e state_reg, state_next;
        wire sleep_req = fb_word[i][`FB_SLEEP_BIT];
        wire float_sel = ref_word[i][`REF_FLOAT_BIT];

        // Float set sleeps at once; float clear waits out the pump pulse
        always_comb begin
            state_next = state_reg;
            unique case (state_reg)
                LOOP_AWAKE: begin
                    if (sleep_req && float_sel) begin
                        state_next = LOOP_ASLEEP;
                    end else if (sleep_req) begin
                        state_next = pump_busy[i] ? LOOP_DRAINING : LOOP_ASLEEP;
                    end
                end
                LOOP_DRAINING: begin
                    if (!sleep_req) begin
                        state_next = LOOP_AWAKE;
                    end else if (float_sel || !pump_busy[i]) begin
                        state_next = LOOP_ASLEEP;
                    end
                end
                LOOP_ASLEEP: begin
                    if (!sleep_req) begin
                        state_next = LOOP_AWAKE;
                    end
                end
                default: state_next = LOOP_AWAKE;
            endcase
        end

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                state_reg <= LOOP_AWAKE;
            end else begin
                state_reg <= state_next;
            end
        end

        assign asleep[i] = state_reg == LOOP_ASLEEP;
        // Pump floats when commanded or while the loop sleeps
        assign pump_float[i] = float_sel || asleep[i];

        loop_divider #(
            .HIGH_BAND(i == 0)
        ) u_div (
            .ref_clk(ref_clk),
            .rst(rst),
            .hold(asleep[i]),
            .rf_tick(rf_tick[i]),
            .osc_tick(osc_tick),
            .coarse_count(fb_word[i][`FB_COARSE_MSB:`FB_COARSE_LSB]),
            .swallow_count(fb_word[i][`FB_SWALLOW_MSB:`FB_SWALLOW_LSB]),
            .modulus_sel(fb_word[i][`FB_MODULUS_BIT]),
            .ref_count(ref_word[i][`REF_COUNT_MSB:`REF_COUNT_LSB]),
            .ref_pulse(ref_pulse[i]),
            .fb_pulse(fb_pulse[i]),
            .pump_up(pump_up[i]),
            .pump_down(pump_down[i]),
            .pump_busy(pump_busy[i])
        );
    end

    // Reference buffer stays on while either loop is awake
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            buffer_on_reg <= 1'b1;
        end else begin
            buffer_on_reg <= !(asleep[0] && asleep[1]);
        end
    end

    assign main_ref_pulse = ref_pulse[0];
    assign main_fb_pulse = fb_pulse[0];
    assign main_pump_up = pump_up[0];
    assign main_pump_down = pump_down[0];
    assign main_pump_high_impedance = pump_float[0];
    assign main_loop_sleep = asleep[0];
    assign second_ref_pulse = ref_pulse[1];
    assign second_fb_pulse = fb_pulse[1];
    assign second_pump_up = pump_up[1];
    assign second_pump_down = pump_down[1];
    assign second_pump_high_impedance = pump_float[1];
    assign second_loop_sleep = asleep[1];
    assign reference_input_buffer = buffer_on_reg;
endmodule

/* hw/pll_fb_consts.svh */
/*
 * Constants for the dual-loop feedback divider and sleep control:
 * serial word layout, address codes, field positions, reset values.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef PLL_FB_CONSTS_SVH
`define PLL_FB_CONSTS_SVH

`define SHIFT_WIDTH 22
`define ADDR_MSB 1
`define ADDR_SECOND_REF 2'h0
`define ADDR_SECOND_FB 2'h1
`define ADDR_MAIN_REF 2'h2
`define ADDR_MAIN_FB 2'h3
`define DATA_MSB 21
`define DATA_LSB 2

// Feedback word fields (after the address is stripped)
`define FB_WORD_WIDTH 20
`define FB_SLEEP_BIT 19
`define FB_MODULUS_BIT 18
`define FB_COARSE_MSB 17
`define FB_COARSE_LSB 5
`define FB_SWALLOW_MSB 4
`define FB_SWALLOW_LSB 0
`define FB_WORD_RESET 20'h00060

// Reference word fields
`define REF_FLOAT_BIT 17
`define REF_COUNT_MSB 14
`define REF_COUNT_LSB 0
`define REF_WORD_RESET 20'h00003

// Prescaler moduli
`define MODULUS_8 6'h08
`define MODULUS_16 6'h10
`define MODULUS_32 6'h20

`endif

/* hw/pll_fb_pkg.sv */
/*
 * Types shared by the feedback divider design.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pll_fb_pkg;
    // Per-loop sleep sequencing, Gray coded along awake -> draining -> asleep
    typedef enum logic [1:0] {
        LOOP_AWAKE = 2'h0,
        LOOP_DRAINING = 2'h1,
        LOOP_ASLEEP = 2'h3
    } sleep_state_e;
    typedef logic [12:0] coarse_t;
    typedef logic [4:0] swallow_t;
    typedef logic [14:0] ref_count_t;
endpackage

/* hw/loop_divider.sv */
/*
 * One loop's counters: pulse-swallow feedback divider, reference divider
 * and a simple phase comparator driving charge pump up/down levels.
 * Assumes rf_tick and osc_tick are one-cycle pulses synchronous to ref_clk.
 */
`include "pll_fb_consts.svh"

module loop_divider
    import pll_fb_pkg::*;
#(
    parameter bit HIGH_BAND = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic rf_tick,
    input wire logic osc_tick,
    input wire coarse_t coarse_count,
    input wire swallow_t swallow_count,
    input wire logic modulus_sel,
    input wire ref_count_t ref_count,
    output logic ref_pulse,
    output logic fb_pulse,
    output logic pump_up,
    output logic pump_down,
    output logic pump_busy
);
    coarse_t coarse_reg, coarse_cnt_reg;
    swallow_t swallow_reg, swallow_cnt_reg;
    logic modulus_sel_reg;
    logic [5:0] pre_cnt_reg;
    ref_count_t ref_cnt_reg;
    logic ref_pulse_reg, fb_pulse_reg, up_reg, down_reg;

    // Modulus pair chosen by band and select bit
    wire [5:0] base_modulus = HIGH_BAND ? (modulus_sel_reg ? `MODULUS_32 : `MODULUS_16)
                                        : (modulus_sel_reg ? `MODULUS_16 : `MODULUS_8);
    // Prescaler divides by P+1 until A cycles are swallowed, then by P
    wire swallowing = swallow_cnt_reg != swallow_reg;
    wire [5:0] pre_last = swallowing ? base_modulus : base_modulus - 6'h01;
    wire pre_done = rf_tick && (pre_cnt_reg == pre_last);
    wire fb_done = pre_done && (coarse_cnt_reg == coarse_reg - 13'h0001);
    // Not shadowed: a smaller new ratio would leave the count past its end,
    // so the compare is at-or-above to end that period instead of wrapping
    wire ref_done = osc_tick && (ref_cnt_reg >= ref_count - 15'h0001);

    // Shadow settings: taken only at a division boundary or while held,
    // so a write never produces a mixed-ratio cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            coarse_reg <= 13'h0003;
            swallow_reg <= 5'h00;
            modulus_sel_reg <= 1'b0;
        end else if (hold || fb_done) begin
            coarse_reg <= coarse_count;
            swallow_reg <= swallow_count;
            modulus_sel_reg <= modulus_sel;
        end
    end

    // Feedback counters, all cleared while held so wake-up starts at zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_cnt_reg <= 6'h00;
            coarse_cnt_reg <= 13'h0000;
            swallow_cnt_reg <= 5'h00;
        end else if (hold || fb_done) begin
            pre_cnt_reg <= 6'h00;
            coarse_cnt_reg <= 13'h0000;
            swallow_cnt_reg <= 5'h00;
        end else if (pre_done) begin
            pre_cnt_reg <= 6'h00;
            coarse_cnt_reg <= coarse_cnt_reg + 13'h0001;
            swallow_cnt_reg <= swallowing ? swallow_cnt_reg + 5'h01 : swallow_cnt_reg;
        end else if (rf_tick) begin
            pre_cnt_reg <= pre_cnt_reg + 6'h01;
        end
    end

    // Reference counter, held at zero alongside the feedback path
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_cnt_reg <= 15'h0000;
        end else if (hold || ref_done) begin
            ref_cnt_reg <= 15'h0000;
        end else if (osc_tick) begin
            ref_cnt_reg <= ref_cnt_reg + 15'h0001;
        end
    end

    // Divider outputs and pump levels; a pump pulse ends when both edges seen
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_pulse_reg <= 1'b0;
            fb_pulse_reg <= 1'b0;
            up_reg <= 1'b0;
            down_reg <= 1'b0;
        end else begin
            ref_pulse_reg <= ref_done && !hold;
            fb_pulse_reg <= fb_done && !hold;
            up_reg <= !hold && !(up_reg && down_reg) && (up_reg || ref_pulse_reg);
            down_reg <= !hold && !(up_reg && down_reg) && (down_reg || fb_pulse_reg);
        end
    end

    assign ref_pulse = ref_pulse_reg;
    assign fb_pulse = fb_pulse_reg;
    assign pump_up = up_reg;
    assign pump_down = down_reg;
    assign pump_busy = up_reg || down_reg;
endmodule

/* testbench/pll_fb_sva.sv */
/* Port checker for the dual-loop divider and its sleep control.
   Assumes legal host settings: B >= 3, R >= 3, ticks at most one a cycle. */
module pll_fb_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic serial_latch_strobe,
    input wire logic osc_tick,
    input wire logic main_rf_tick,
    input wire logic second_rf_tick,
    input wire logic main_ref_pulse,
    input wire logic main_fb_pulse,
    input wire logic main_pump_up,
    input wire logic main_pump_down,
    input wire logic main_pump_high_impedance,
    input wire logic main_loop_sleep,
    input wire logic second_ref_pulse,
    input wire logic second_fb_pulse,
    input wire logic second_pump_up,
    input wire logic second_pump_down,
    input wire logic second_pump_high_impedance,
    input wire logic second_loop_sleep,
    input wire logic reference_input_buffer
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Smallest main ratio is 16*3, so feedback pulses never crowd
    chk_fb_spacing: assert property (main_fb_pulse |=> (!main_fb_pulse) [*8])
        else $error("feedback pulses too close");
    chk_ref_spacing: assert property (second_ref_pulse |=> (!second_ref_pulse) [*2])
        else $error("reference pulses too close");
    chk_asleep_quiet: assert property (main_loop_sleep && $past(main_loop_sleep)
        |-> !main_fb_pulse && !main_ref_pulse)
        else $error("divider pulse while asleep");
    chk_wake_zero: assert property ($fell(main_loop_sleep)
        |-> (!main_fb_pulse && !main_ref_pulse) [*3])
        else $error("counters not restarted from zero");
    chk_sleep_floats: assert property (second_loop_sleep |-> second_pump_high_impedance)
        else $error("pump not floated while asleep");
    // Float clear before sleeping means the pump had to go idle first
    chk_sync_drain: assert property ($rose(second_loop_sleep)
        && !$past(second_pump_high_impedance) |-> $past(!second_pump_up && !second_pump_down))
        else $error("sleep entered during pump pulse");
    chk_buffer_both: assert property (
        reference_input_buffer == !$past(main_loop_sleep && second_loop_sleep))
        else $error("reference buffer state wrong");
    chk_pump_clear: assert property (main_pump_up && main_pump_down
        && !main_ref_pulse && !main_fb_pulse |=> !main_pump_up && !main_pump_down)
        else $error("pump pulse did not end");
endmodule

bind pll_feedback_divider_powerdown pll_fb_checker chk (.*);

/* testbench/serial_host.sv */
/* Serial host model: shifts 22-bit words into the programming port.
   Assumes calls start on a falling ref_clk edge. */
module serial_host (
    input wire logic ref_clk,
    output logic serial_clock,
    output logic serial_data,
    output logic serial_latch_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle low at time zero
    initial begin
        serial_clock = 1'h0;
        serial_data = 1'h0;
        serial_latch_strobe = 1'h0;
    end
    // Each level held two cycles so the sampler sees every edge
    task automatic send(input logic [21:0] w);
        for (int i = 21; i >= 0; i--) begin
            serial_data = w[i];
            repeat (2) @(negedge ref_clk);
            serial_clock = 1'h1;
            repeat (2) @(negedge ref_clk);
            serial_clock = 1'h0;
        end
        serial_data = ~serial_data; // data line inverted, last value not kept
        repeat (2) @(negedge ref_clk);
        serial_latch_strobe = 1'h1;
        repeat (2) @(negedge ref_clk);
        serial_latch_strobe = 1'h0;
    endtask
endmodule

/* testbench/tb_top.sv */
/* Top bench: serial host, random tick streams and a period monitor.
   Assumes a pulse follows the tick that ends its division by one cycle. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, serial_clock, serial_data, serial_latch_strobe, run;
    logic osc_tick, main_rf_tick, second_rf_tick, main_ref_pulse, main_fb_pulse;
    logic main_pump_up, main_pump_down, main_pump_high_impedance, main_loop_sleep;
    logic second_ref_pulse, second_fb_pulse, second_pump_up, second_pump_down;
    logic second_pump_high_impedance, second_loop_sleep, reference_input_buffer;
    logic [3:0] pul, tik, slp;
    int cnt[4], per[4], seen[4];
    int seed, mismatches, n_checks, b, a, r, p, m, w;

    pll_feedback_divider_powerdown dut (.*);
    serial_host host (.*);

    // Monitor lanes: main fb, second fb, main ref, second ref
    assign pul = {second_ref_pulse, main_ref_pulse, second_fb_pulse, main_fb_pulse};
    assign tik = {osc_tick, osc_tick, second_rf_tick, main_rf_tick};
    assign slp = {second_loop_sleep, main_loop_sleep, second_loop_sleep, main_loop_sleep};

    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Random ticks, stopped while a wake-up is set up
    always @(negedge ref_clk) begin
        {main_rf_tick, second_rf_tick, osc_tick} <= run ? 3'($random(seed)) : 3'h0;
    end

    // Ticks since the last pulse; a sleeping loop restarts from zero
    always @(posedge ref_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (slp[i] || rst) cnt[i] = 0;
            else if (pul[i]) begin
                per[i] = cnt[i];
                seen[i]++;
                cnt[i] = int'(tik[i]);
            end else cnt[i] += int'(tik[i]);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [21:0] fbw(logic s, logic sel, int bb, int aa, logic [1:0] ad);
        return {s, sel, 13'(bb), 5'(aa), ad};
    endfunction

    function automatic logic [21:0] refw(logic fl, int rr, logic [1:0] ad);
        return {2'h0, fl, 2'h0, 15'(rr), ad};
    endfunction

    // Skip skip intervals (the one in progress when skip is 1), then compare one whole period
    task automatic measure(input int i, input int exp, input int skip);
        int s;
        int t;
        s = seen[i];
        t = 0;
        while (seen[i] < s + skip + 1 && t < 3000) begin
            @(negedge ref_clk);
            t++;
        end
        chk(per[i], exp);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard, far beyond the longest expected run
    initial begin
        #400us;
        mismatches++;
        results();
    end

    initial begin
        seed = 32'h9036571b;
        rst = 1'h1;
        run = 1'h0;
        repeat (5) @(negedge ref_clk);
        rst = 1'h0;
        run = 1'h1;
        chk(reference_input_buffer, 1);
        measure(0, 48, 1);
        measure(2, 3, 1);
        $display("test reset_values done");
        // Every loop with both modulus pairs; last two use the largest swallow
        for (int k = 0; k < 4; k++) begin
            p = (k % 2) ? ((k / 2) ? 16 : 8) : ((k / 2) ? 32 : 16);
            b = 3 + {$random(seed)} % 8;
            m = (b < p) ? b : p;
            a = (k > 1) ? m - 1 : {$random(seed)} % m;
            host.send(fbw(0, k / 2, b, a, (k % 2) ? 2'h1 : 2'h3));
            measure(k % 2, p * b + a, 1);
            r = 3 + {$random(seed)} % 6;
            host.send(refw(0, r, (k % 2) ? 2'h0 : 2'h2));
            measure(2 + k % 2, r, 1);
            $display("test ratio %0d done", k);
        end
        host.send(refw(1, 4, 2'h2));
        host.send(fbw(1, 0, 3, 0, 2'h3));
        chk(main_loop_sleep, 1);
        chk(main_pump_high_impedance, 1);
        host.send(refw(0, 4, 2'h0));
        host.send(fbw(1, 0, 3, 0, 2'h1));
        // Pump up may wait a whole feedback period for its down edge
        w = 0;
        while (second_loop_sleep !== 1'h1 && w < 2000) begin
            @(negedge ref_clk);
            w++;
        end
        chk(second_loop_sleep, 1);
        @(negedge ref_clk);
        chk(reference_input_buffer, 0);
        $display("test sleep done");
        run = 1'h0;
        host.send(fbw(0, 0, 3, 0, 2'h3));
        chk(main_loop_sleep, 0);
        @(negedge ref_clk);
        chk(reference_input_buffer, 1);
        run = 1'h1;
        measure(2, 4, 0);
        measure(0, 48, 0);
        $display("test wake done");
        results();
    end
endmodule
